// file: rtl/gpio_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Register map and field layout of the port block
// ----------------------------------------------------------------
package gpio_pkg;
  // Pin count: ports zero to three carry 8 pins, port four carries 4.
  localparam int PIN_COUNT  = 36;
  localparam int PORT_COUNT = 5;
  localparam int LOCAL_PINS = 16;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] IDX_PORT0    = 6'h00;
  localparam logic [5:0] IDX_PORT4    = 6'h04;
  localparam logic [5:0] IDX_MODE     = 6'h05;
  localparam logic [5:0] IDX_CFG_BASE = 6'h08;
  localparam logic [5:0] IDX_CFG_LAST = 6'h2B;

  // Writable bits of the port four data register.
  localparam logic [7:0] PORT4_MASK = 8'h0F;

  // Per-pin configuration register fields.
  localparam int CFG_OE      = 0;
  localparam int CFG_PULL    = 1;
  localparam int CFG_OD      = 2;
  localparam int CFG_SINK    = 3;
  localparam int CFG_TTL     = 4;
  localparam int CFG_ACT_LOW = 5;
  localparam int CFG_INT_EN  = 6;
  localparam int CFG_ALT     = 7;

  // Mode register fields.
  localparam int MODE_REGULATED_SUPPLY_OUT  = 0;
  localparam int MODE_SPI   = 1;
  localparam int MODE_USB   = 2;
  localparam int MODE_FORCE = 3;
  localparam int MODE_XOSC  = 4;

  // Pin numbers of the shared functions (port*8 + bit).
  localparam int PIN_CLK_IN  = 0;
  localparam int PIN_CLK_OUT = 1;
  localparam int PIN_IRQ_LO  = 2;
  localparam int PIN_TIMER_A = 5;
  localparam int PIN_TIMER_B = 6;
  localparam int PIN_USB_DP  = 8;
  localparam int PIN_USB_DM  = 9;
  localparam int PIN_REGULATED_SUPPLY_OUT    = 10;
  localparam int PIN_SPI_LO  = 11;

  // Values after reset.
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
endpackage
`default_nettype wire

// file: rtl/gpio_port.sv
// What this block does
// RL1: Port data write sets enabled pin drive levels.
// RL2: Port data read returns sampled pin levels.
// RL3: Port four bits 7..4 reserved, read zero.
// RL4: Port0 pins 6,5 double as timer pins.
// RL5: Port0 pins 4..2 double as external interrupts.
// RL6: Port0 pin1 clock output, pin0 clock input.
// RL7: Port1 pins 6..3 double as serial interface.
// RL8: Regulator enable puts supply on port1 pin2.
// RL9: USB mode turns port1 pins 1,0 into D-/D+.
// RL10: Force state: data bits drive D-/D+ directly.
// RL11: Interrupt enable gates pin interrupts, any direction.
// RL12: Edge interrupts; shared one rearms after all deassert.
// RL13: Polarity bit set falling edge, clear rising.
// RL14: Driving an output pin can raise interrupts.
// RL15: Threshold bit set TTL, clear CMOS.
// RL16: Strong-sink bit set 50 mA, clear 8 mA.
// RL17: Open drain: one floats, zero pulls low.
// RL18: Pull-up bit connects the pin pull-up.
// RL19: Output enable bit turns the driver on.
// RL20: Everything resets to zero, pins become inputs.
// RL21: Pins synchronised, one pulse per qualifying edge.
`default_nettype none
module gpio_port
  import gpio_pkg::*;
(
  input  wire logic                           clk_i,
  input  wire logic                           rst_i,
  // Wishbone classic slave.
  input  wire logic                           cyc_i,
  input  wire logic                           stb_i,
  input  wire logic                           we_i,
  input  wire logic [7:0]                     adr_i,
  input  wire logic [3:0]                     sel_i,
  input  wire logic [31:0]                    dat_i,
  output logic      [31:0]                    dat_o,
  output logic                                ack_o,
  // Pad side: level seen on the wire, drive value and enable.
  input  wire logic [gpio_pkg::PIN_COUNT-1:0] pin_i,
  output logic      [gpio_pkg::PIN_COUNT-1:0] pin_o,
  output logic      [gpio_pkg::PIN_COUNT-1:0] pin_oe_o,
  output logic      [gpio_pkg::PIN_COUNT-1:0] pull_up_o,
  output logic      [gpio_pkg::PIN_COUNT-1:0] high_sink_o,
  output logic      [gpio_pkg::PIN_COUNT-1:0] ttl_thresh_o,
  // Shared functions.
  input  wire logic [1:0]                     timer_io_out_i,
  output logic      [1:0]                     timer_io_in_o,
  input  wire logic                           clk_source_i,
  output logic                                clock_input_pin_o,
  input  wire logic [3:0]                     spi_out_i,
  input  wire logic [3:0]                     spi_oe_i,
  output logic      [3:0]                     spi_in_o,
  input  wire logic [1:0]                     usb_tx_i,
  input  wire logic                           usb_oe_i,
  output logic      [1:0]                     usb_rx_o,
  output logic                                regulated_supply_out_o,
  // Interrupt request pulses.
  output logic      [gpio_pkg::LOCAL_PINS-1:0] pin_irq_o,
  output logic                                shared_irq_o
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]           port_data [PORT_COUNT]; // Written drive levels.
  logic [7:0]           cfg [PIN_COUNT];        // One byte per pin.
  logic [7:0]           mode;                   // Shared-function enables.
  logic [PIN_COUNT-1:0] sync_a;                 // First stage, read by sync_b only.
  logic [PIN_COUNT-1:0] sync_b;                 // Settled pin level.
  logic [PIN_COUNT-1:0] assert_q;               // Asserted state, one cycle old.
  logic                 any_q;                  // Shared group state, one cycle old.
  logic                 ack;                    // Answer to the bus.
  logic [7:0]           rd_q;                   // Read data byte.

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A request is taken once; the ack register closes it.
  wire       req      = cyc_i & stb_i & ~ack;
  wire       wr_en    = req & we_i & sel_i[0];
  wire [5:0] idx      = adr_i[7:2];
  wire       hit_data = (idx <= IDX_PORT4);
  wire       hit_mode = (idx == IDX_MODE);
  wire       hit_cfg  = (idx >= IDX_CFG_BASE) && (idx <= IDX_CFG_LAST);
  // Wraps below the base, but it is only used under hit_cfg.
  wire [5:0] cfg_idx  = idx - IDX_CFG_BASE;
  wire [2:0] port_idx = idx[2:0];
  wire [7:0] wbyte    = dat_i[7:0];

  // Port four keeps only its low nibble.
  wire [7:0] port_wmask = (idx == IDX_PORT4) ? PORT4_MASK : 8'hFF; // RL3

  // Flat views of written data and of the sampled pins.
  logic [8*PORT_COUNT-1:0] data_vec;
  // Port four has four pins; the zero pad keeps its byte select whole.
  wire  [8*PORT_COUNT-1:0] pin_pad = {4'h0, sync_b};

  genvar gp;
  generate
    for (gp = 0; gp < PORT_COUNT; gp++) begin : g_flat
      assign data_vec[gp*8 +: 8] = port_data[gp];
    end
  endgenerate

  // Reads of a data register see the pins, not the stored byte.
  wire [7:0] pin_byte = pin_pad[{port_idx, 3'b000} +: 8]; // RL2
  wire [7:0] rd_byte  = hit_data ? (pin_byte & port_wmask) : // RL3
                        hit_mode ? mode :
                        hit_cfg  ? cfg[cfg_idx] : 8'h00;

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Every access, mapped or not, is acked one cycle after it is
  // taken; unmapped reads return zero and unmapped writes vanish.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack  <= 1'b0;
      rd_q <= 8'h00;
    end else begin
      ack <= req;
      if (req) begin
        rd_q <= rd_byte;
      end
    end
  end

  assign ack_o = ack;
  assign dat_o = {24'h0, rd_q};

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Writes land at the edge that takes the request, so the new value
  // already stands when the master sees ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        port_data[p] <= DATA_RESET; // RL20
      end
      for (int k = 0; k < PIN_COUNT; k++) begin
        cfg[k] <= CFG_RESET; // RL20
      end
      mode <= MODE_RESET; // RL20
    end else if (wr_en) begin
      if (hit_data) begin
        port_data[port_idx] <= wbyte & port_wmask; // RL1 RL3
      end
      if (hit_mode) begin
        mode <= wbyte;
      end
      if (hit_cfg) begin
        cfg[cfg_idx] <= wbyte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  // Pins are asynchronous; only the second stage is used anywhere.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= pin_i; // RL21
      sync_b <= sync_a; // RL21
    end
  end

  // ----------------------------------------------------------------
  // Per-pin plain I/O and interrupt qualification
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] base_o;   // Drive value before overrides.
  logic [PIN_COUNT-1:0] base_oe;  // Drive enable before overrides.
  logic [PIN_COUNT-1:0] asserted; // Pin at its active level and enabled.

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
      wire [7:0] c = cfg[gi];
      // Open drain floats a one and pulls a zero low.
      assign base_o[gi]  = c[CFG_OD] ? 1'b0 : data_vec[gi]; // RL17
      assign base_oe[gi] = c[CFG_OE] & ~(c[CFG_OD] & data_vec[gi]); // RL19 RL17
      // The level is taken from the wire, so a pin the block drives
      // itself raises its own interrupt too.
      assign asserted[gi] = c[CFG_INT_EN] & // RL11 RL14
                            (c[CFG_ACT_LOW] ? ~sync_b[gi] : sync_b[gi]); // RL13
      assign pull_up_o[gi]    = c[CFG_PULL]; // RL18
      assign high_sink_o[gi]  = c[CFG_SINK]; // RL16
      assign ttl_thresh_o[gi] = c[CFG_TTL]; // RL15
    end
  endgenerate

  // ----------------------------------------------------------------
  // Shared-function overrides
  // ----------------------------------------------------------------
  logic [PIN_COUNT-1:0] next_pin_o;
  logic [PIN_COUNT-1:0] next_pin_oe;

  // Later branches win, but the pins they touch do not overlap.
  always_comb begin
    next_pin_o  = base_o;
    next_pin_oe = base_oe;
    // Crystal use takes both clock pins away from plain I/O.
    if (mode[MODE_XOSC]) begin
      next_pin_oe[PIN_CLK_IN]  = 1'b0; // RL6
      next_pin_oe[PIN_CLK_OUT] = 1'b0; // RL6
    end else if (cfg[PIN_CLK_OUT][CFG_ALT]) begin
      next_pin_o[PIN_CLK_OUT]  = clk_source_i; // RL6
      next_pin_oe[PIN_CLK_OUT] = 1'b1;
    end
    // Timer outputs replace the data bit; the enable stays the pin's.
    if (cfg[PIN_TIMER_A][CFG_ALT]) begin
      next_pin_o[PIN_TIMER_A] = timer_io_out_i[0]; // RL4
    end
    if (cfg[PIN_TIMER_B][CFG_ALT]) begin
      next_pin_o[PIN_TIMER_B] = timer_io_out_i[1]; // RL4
    end
    // The regulator pin loses its driver while the supply is out.
    if (mode[MODE_REGULATED_SUPPLY_OUT]) begin
      next_pin_oe[PIN_REGULATED_SUPPLY_OUT] = 1'b0; // RL8
    end
    // The serial engine owns value and enable of its four pins.
    if (mode[MODE_SPI]) begin
      next_pin_o[PIN_SPI_LO +: 4]  = spi_out_i; // RL7
      next_pin_oe[PIN_SPI_LO +: 4] = spi_oe_i; // RL7
    end
    // USB mode hands D-/D+ to the transceiver unless forced.
    if (mode[MODE_USB]) begin
      if (mode[MODE_FORCE]) begin
        next_pin_o[PIN_USB_DP +: 2]  = data_vec[PIN_USB_DP +: 2]; // RL10
        next_pin_oe[PIN_USB_DP +: 2] = 2'b11; // RL10
      end else begin
        next_pin_o[PIN_USB_DP +: 2]  = usb_tx_i; // RL9
        next_pin_oe[PIN_USB_DP +: 2] = {2{usb_oe_i}}; // RL9
      end
    end
  end

  // Pad drive is registered so the pads never see decode glitches;
  // the cost is one cycle from a register write to the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o    <= '0;
      pin_oe_o <= '0; // RL20
    end else begin
      pin_o    <= next_pin_o; // RL1
      pin_oe_o <= next_pin_oe; // RL1
    end
  end

  // Settled inputs for the shared functions, and the regulator enable.
  assign timer_io_in_o          = sync_b[PIN_TIMER_A +: 2]; // RL4
  assign clock_input_pin_o      = sync_b[PIN_CLK_IN]; // RL6
  assign spi_in_o               = sync_b[PIN_SPI_LO +: 4]; // RL7
  assign usb_rx_o               = sync_b[PIN_USB_DP +: 2]; // RL9
  assign regulated_supply_out_o = mode[MODE_REGULATED_SUPPLY_OUT]; // RL8

  // ----------------------------------------------------------------
  // Interrupt pulses
  // ----------------------------------------------------------------
  // Ports zero and one have one request per pin; pins 4..2 of port
  // zero are the three external requests.  Ports two to four share
  // one request, which rises only when the whole group was idle, so
  // a second pin asserting while another still holds gives nothing.
  // The polarity bit feeds the qualifier directly, so flipping it on a
  // quiet pin can raise a pulse; firmware should mask the pin first.
  wire any_asserted = |asserted[PIN_COUNT-1:LOCAL_PINS];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      assert_q     <= '0;
      any_q        <= 1'b0;
      pin_irq_o    <= '0;
      shared_irq_o <= 1'b0;
    end else begin
      assert_q     <= asserted; // RL21
      any_q        <= any_asserted;
      pin_irq_o    <= asserted[LOCAL_PINS-1:0] & ~assert_q[LOCAL_PINS-1:0]; // RL5 RL12
      shared_irq_o <= any_asserted & ~any_q; // RL12
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_write_port0;
    req && we_i && sel_i[0] && (idx == IDX_PORT0);
  endsequence

  sequence s_read_port1;
    req && !we_i && (idx == IDX_PORT0 + 6'h01);
  endsequence

  sequence s_read_port4;
    req && !we_i && (idx == IDX_PORT4);
  endsequence

  // A data write reaches a plain push-pull output two edges later.
  chk_data_drive: assert property ( // RL1
    s_write_port0 ##1 (cfg[7][CFG_OE] && !cfg[7][CFG_OD])
      |=> pin_o[7] == $past(dat_i[7], 2) && pin_oe_o[7])
    else $error("port0 pin7 not driven with written data");

  // Read data shows the settled pins, not the stored byte.
  chk_read_pins: assert property ( // RL2
    s_read_port1 |=> ack_o && dat_o[7:0] == $past(sync_b[15:8]))
    else $error("port1 read does not show pin levels");

  // Reserved port four bits neither read back nor store anything.
  chk_port4_rsvd: assert property ( // RL3
    s_read_port4 |=> dat_o[7:4] == 4'h0 && port_data[4][7:4] == 4'h0)
    else $error("port4 reserved bits not zero");

  // The pad enable lags the mode by one edge, so it is checked then.
  chk_regulated_supply_out_off: assert property ( // RL8
    mode[MODE_REGULATED_SUPPLY_OUT] |-> regulated_supply_out_o ##1 !pin_oe_o[PIN_REGULATED_SUPPLY_OUT])
    else $error("regulator pin still driven");

  // Forced state copies the two data bits onto D-/D+ with drive on.
  chk_usb_force: assert property ( // RL10
    mode[MODE_USB] && mode[MODE_FORCE]
      |=> pin_oe_o[9:8] == 2'b11 && pin_o[9:8] == $past(port_data[1][1:0]))
    else $error("forced D-/D+ not from data bits");

  // The serial engine owns both value and enable of its pins.
  chk_spi_route: assert property ( // RL7
    mode[MODE_SPI] |=> pin_o[14:11] == $past(spi_out_i)
                       && pin_oe_o[14:11] == $past(spi_oe_i))
    else $error("serial pins not owned by the engine");

  // Crystal use takes both clock pins off the pad drivers.
  chk_xosc_off: assert property ( // RL6
    mode[MODE_XOSC] |=> pin_oe_o[PIN_CLK_IN +: 2] == 2'b00)
    else $error("clock pins driven during crystal use");

  // An open-drain pin without a shared function may pull low but never drive high.
  chk_od_float: assert property ( // RL17
    cfg[16][CFG_OD] |=> !(pin_oe_o[16] && pin_o[16]))
    else $error("open drain pin drove high");

  // A request needs an enabled active level that was not active before.
  chk_irq_cause: assert property ( // RL11 RL13
    pin_irq_o[3] |-> $past(cfg[3][CFG_INT_EN])
      && $past(sync_b[3]) != $past(cfg[3][CFG_ACT_LOW])
      && (!$past(cfg[3][CFG_INT_EN], 2)
          || $past(sync_b[3], 2) == $past(cfg[3][CFG_ACT_LOW], 2)))
    else $error("pin3 request without enabled qualifying edge");

  // Each request is a single-cycle pulse.
  chk_irq_pulse: assert property ( // RL21
    pin_irq_o[3] |=> !pin_irq_o[3])
    else $error("pin3 request longer than one cycle");

  // The shared request only rises out of an idle group.
  chk_shared_rearm: assert property ( // RL12
    shared_irq_o |-> !$past(any_q) ##1 !shared_irq_o)
    else $error("shared request without idle group");

  // Straight after reset every pad is an input, the mode is at reset and pin request 0 is low.
  chk_reset_idle: assert property ( // RL20
    $past(rst_i) |-> pin_oe_o == '0 && mode == MODE_RESET && !pin_irq_o[0])
    else $error("pins not idle after reset");

endmodule
`default_nettype wire

// file: sim/pin_board.sv
`default_nettype none
// --------------------
// Board side of the pads
// --------------------
module pin_board (
  input  wire logic        clk_i,
  input  wire logic [35:0] drive_i,
  input  wire logic [35:0] drive_oe_i,
  input  wire logic [35:0] pull_up_i,
  input  wire logic [35:0] ext_val_i,
  input  wire logic [35:0] ext_oe_i,
  output logic      [35:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // An undriven line without pull-up keeps changing, so a stale level never reads as valid.
  logic [35:0] flt = 36'h0;
  always @(posedge clk_i) begin
    flt <= ~flt;
  end
  // The chip wins where it drives, then the board, then the pull-up.
  assign pad_o = (drive_oe_i & drive_i) | (~drive_oe_i & ext_oe_i & ext_val_i) |
                 (~drive_oe_i & ~ext_oe_i & (pull_up_i | flt));
endmodule
`default_nettype wire

// file: sim/testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_pkg::*;
  logic                 clk_i, rst_i, cyc, stb, we, ack, clk_src, clk_in, usb_oe, reg_out, sh_irq;
  logic [7:0]           adr, rd;
  logic [3:0]           sel, spi_out, spi_oe, spi_in;
  logic [31:0]          dat_w, dat_r;
  logic [PIN_COUNT-1:0] pad, pin_o, pin_oe, pull_up, high_sink, ttl, ext_val, ext_oe;
  logic [1:0]           tmr_out, tmr_in, usb_tx, usb_rx;
  logic [15:0]          pin_irq;
  int                   n_errors, n_checks, sh_cnt, q;
  int                   irq_cnt[16];

  gpio_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .pin_i(pad),
    .pin_o(pin_o), .pin_oe_o(pin_oe), .pull_up_o(pull_up), .high_sink_o(high_sink),
    .ttl_thresh_o(ttl), .timer_io_out_i(tmr_out), .timer_io_in_o(tmr_in),
    .clk_source_i(clk_src), .clock_input_pin_o(clk_in), .spi_out_i(spi_out),
    .spi_oe_i(spi_oe), .spi_in_o(spi_in), .usb_tx_i(usb_tx), .usb_oe_i(usb_oe),
    .usb_rx_o(usb_rx), .regulated_supply_out_o(reg_out), .pin_irq_o(pin_irq),
    .shared_irq_o(sh_irq));
  pin_board u_board (.clk_i(clk_i), .drive_i(pin_o), .drive_oe_i(pin_oe),
    .pull_up_i(pull_up), .ext_val_i(ext_val), .ext_oe_i(ext_oe), .pad_o(pad));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // Interrupt pulses are counted at the edge that samples them, once per cycle high.
  always @(posedge clk_i) begin
    for (int i = 0; i < 16; i++) if (pin_irq[i] === 1'b1) irq_cnt[i]++;
    if (sh_irq === 1'b1) sh_cnt++;
  end

  // --------------------
  // Shared tasks
  // --------------------
  task chk(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One classic cycle; the request stands until ack is sampled, only the watchdog ends a wait.
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    sel   <= 4'hF;
    adr   <= a;
    dat_w <= {24'h000000, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk({28'h0, rd & m}, {28'h0, e});
  endtask
  task cfg(input int p, input logic [7:0] v);
    wb(1'b1, 8'(32 + 4 * p), v);
  endtask
  task zero();
    for (int i = 0; i < 16; i++) irq_cnt[i] = 0;
    sh_cnt = 0;
  endtask
  task pulse(input int p);
    ext_val[p] <= 1'b1;
    idle(8);
    ext_val[p] <= 1'b0;
    idle(8);
  endtask
  task done(input string s);
    $display("test %s finished", s);
  endtask
  task close_out();
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A hang ends the run through the same closing task.
  initial begin
    #100000;
    n_errors++;
    close_out();
  end

  // --------------------
  // Test sequence
  // --------------------
  initial begin
    {rst_i, cyc, stb, we, clk_src, usb_oe} = 6'b100000;
    {adr, dat_w, sel, spi_out, spi_oe, tmr_out, usb_tx} = '0;
    sel = 4'hF;
    {ext_val, ext_oe} = '0;
    zero();
    idle(5);
    rst_i <= 1'b0;
    for (q = 0; q < 36; q++) rdc(8'(32 + 4 * q), 8'hFF, 8'h00);
    rdc(8'h14, 8'hFF, 8'h00);
    wr(8'h18, 8'h5A);
    rdc(8'h18, 8'hFF, 8'h00);
    chk(pin_oe | pull_up | high_sink | ttl, 36'h0);
    done("reset");
    for (q = 0; q < 8; q++) cfg(q, 8'h01);
    wr(8'h00, 8'hA5);
    idle(4);
    chk({pin_oe[7:0], pin_o[7:0]} & 36'hFFFF, 36'hFFA5);
    rdc(8'h00, 8'hFF, 8'hA5);
    ext_oe[7] <= 1'b1;
    cfg(7, 8'h00);
    idle(4);
    rdc(8'h00, 8'hFF, 8'h25);
    for (q = 32; q < 36; q++) cfg(q, 8'h01);
    wr(8'h10, 8'hFF);
    idle(4);
    chk({32'h0, pin_o[35:32]}, 36'hF);
    rdc(8'h10, 8'hFF, 8'h0F);
    done("data");
    // Open drain with pull-up: a one floats and the pull-up wins.
    cfg(16, 8'h07);
    wr(8'h08, 8'h01);
    idle(4);
    chk({34'h0, pin_oe[16], pull_up[16]}, 36'h1);
    rdc(8'h08, 8'h01, 8'h01);
    wr(8'h08, 8'h00);
    idle(4);
    chk({34'h0, pin_oe[16], pin_o[16]}, 36'h2);
    cfg(16, 8'h01);
    wr(8'h08, 8'h01);
    idle(4);
    chk({34'h0, pin_oe[16], pin_o[16]}, 36'h3);
    cfg(20, 8'h18);
    idle(2);
    chk({33'h0, pull_up[20], high_sink[20], ttl[20]}, 36'h3);
    cfg(20, 8'h02);
    idle(2);
    chk({33'h0, pull_up[20], high_sink[20], ttl[20]}, 36'h4);
    done("pad");
    // Polarity changes may fire a pulse, so counts are cleared after each setup.
    for (q = 2; q < 5; q++) begin
      ext_oe[q] <= 1'b1;
      cfg(q, 8'h40);
      idle(8);
      zero();
      pulse(q);
      chk(36'(irq_cnt[q]), 36'd1);
      cfg(q, 8'h60);
      idle(8);
      ext_val[q] <= 1'b1;
      idle(8);
      zero();
      ext_val[q] <= 1'b0;
      idle(8);
      chk(36'(irq_cnt[q]), 36'd1);
      cfg(q, 8'h20);
      zero();
      pulse(q);
      chk(36'(irq_cnt[q]), 36'd0);
    end
    wr(8'h04, 8'h00);
    cfg(15, 8'h41);
    idle(8);
    zero();
    wr(8'h04, 8'h80);
    idle(8);
    chk(36'(irq_cnt[15]), 36'd1);
    ext_oe[16] <= 1'b1;
    ext_oe[24] <= 1'b1;
    cfg(16, 8'h40);
    cfg(24, 8'h40);
    idle(8);
    zero();
    ext_val[16] <= 1'b1;
    idle(8);
    chk(36'(sh_cnt), 36'd1);
    ext_val[24] <= 1'b1;
    idle(8);
    pulse(16);
    ext_val[16] <= 1'b1;
    idle(8);
    chk(36'(sh_cnt), 36'd1);
    ext_val[16] <= 1'b0;
    ext_val[24] <= 1'b0;
    idle(8);
    ext_val[24] <= 1'b1;
    idle(8);
    chk(36'(sh_cnt), 36'd2);
    done("interrupts");
    wr(8'h14, 8'h01);
    cfg(10, 8'h01);
    idle(3);
    chk({34'h0, reg_out, pin_oe[10]}, 36'h2);
    wr(8'h14, 8'h0C);
    wr(8'h04, 8'h01);
    idle(3);
    chk({32'h0, pin_oe[9:8], pin_o[9:8]}, 36'hD);
    usb_tx <= 2'b10;
    usb_oe <= 1'b1;
    wr(8'h14, 8'h04);
    idle(3);
    chk({32'h0, pin_oe[9:8], pin_o[9:8]}, 36'hE);
    usb_oe <= 1'b0;
    ext_oe[9:8] <= 2'b11;
    ext_val[9:8] <= 2'b10;
    idle(6);
    chk({34'h0, usb_rx}, 36'h2);
    ext_oe[9:8] <= 2'b00;
    wr(8'h14, 8'h00);
    cfg(8, 8'h01);
    cfg(9, 8'h01);
    idle(3);
    chk({32'h0, pin_oe[9:8], pin_o[9:8]}, 36'hD);
    rdc(8'h04, 8'h07, 8'h01);
    spi_out <= 4'hA;
    spi_oe <= 4'hF;
    wr(8'h14, 8'h02);
    idle(3);
    chk({28'h0, pin_oe[14:11], pin_o[14:11]}, 36'hFA);
    spi_oe <= 4'h0;
    ext_oe[14:11] <= 4'hF;
    ext_val[14:11] <= 4'h5;
    idle(6);
    chk({32'h0, spi_in}, 36'h5);
    tmr_out <= 2'b10;
    cfg(5, 8'h81);
    cfg(6, 8'h81);
    idle(3);
    chk({32'h0, pin_oe[6:5], pin_o[6:5]}, 36'hE);
    ext_oe[6:5] <= 2'b11;
    cfg(5, 8'h00);
    cfg(6, 8'h00);
    ext_val[6:5] <= 2'b10;
    idle(6);
    chk({34'h0, tmr_in}, 36'h2);
    clk_src <= 1'b1;
    cfg(1, 8'h81);
    idle(3);
    chk({35'h0, pin_o[1]}, 36'h1);
    ext_oe[0] <= 1'b1;
    cfg(0, 8'h00);
    ext_val[0] <= 1'b1;
    idle(6);
    chk({35'h0, clk_in}, 36'h1);
    wr(8'h14, 8'h10);
    idle(3);
    chk({34'h0, pin_oe[1:0]}, 36'h0);
    done("shared functions");
    close_out();
  end
endmodule
`default_nettype wire
